// ---- verilog/ltmc_pkg.sv ----
// Package for the transceiver mode controller: mode codes, timing counts
// and the condition-flag carrier.
// Assumes a 50 MHz system clock on every module that imports it.
package ltmc_pkg;

  // System clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 20000;

  // Wake filter least low time on the bus, in microseconds.
  localparam int unsigned WAKE_FILTER_US = 10;
  localparam int unsigned WAKE_FILTER_CYC =
    (WAKE_FILTER_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Contention compare debounce, in nanoseconds, covers bus delay.
  localparam int unsigned CONTEND_NS = 2000;
  localparam int unsigned CONTEND_CYC =
    (CONTEND_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Depth of the pin synchroniser.
  localparam int unsigned SYNC_STAGES = 3;

  // Operating modes, one-hot.
  typedef enum logic [4:0] {
    LTMC_POR   = 5'h01,
    LTMC_READY = 5'h02,
    LTMC_OPER  = 5'h04,
    LTMC_PDOWN = 5'h08,
    LTMC_TXOFF = 5'h10
  } ltmc_mode_t;

  localparam logic [4:0] MODE_RESET = 5'h01;

  // Synchronised analog condition flags.
  typedef struct packed {
    logic batt_above_on;
    logic batt_below_off;
    logic reg_good;
    logic thermal_ovl;
    logic bus_below_wake;
  } ltmc_cond_t;

  localparam int unsigned COND_W = 5;

endpackage : ltmc_pkg

// ---- verilog/ltmc_sync.sv ----
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module ltmc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import ltmc_pkg::*;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Elaboration-time guard: a zero-width synchroniser has nothing to do.
  if (WIDTH < 1) begin : g_bad_width
    $error("ltmc_sync: WIDTH must be at least 1");
  end

  // The first stage feeds the second only; agreement of the later two
  // decides the output, which rejects a single metastable sample.
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        s1_q[i]     <= RESET_VAL[i];
        s2_q[i]     <= RESET_VAL[i];
        s3_q[i]     <= RESET_VAL[i];
        sync_out[i] <= RESET_VAL[i];
      end else begin
        s1_q[i] <= async_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule : ltmc_sync

// ---- verilog/ltmc_mode_ctrl.sv ----
// Operating-mode controller of a single-wire bus transceiver with regulator.
// Assumes analog comparators arrive as asynchronous digital levels and the
// host drives chip select and the open-drain fault line from outside.
// Operation
// - After supply comes up hold reset state until battery above on level.
// - Battery below off level returns to reset state from any mode.
// - Power-down keeps transmitter and regulator off; receiver and wake on.
// - Bus wake or chip select high leaves power-down via ready.
// - Power-down is entered only from operation or transmitter-off mode.
// - Ready powers regulator and receiver, transmitter off, bus recessive.
// - Ready waits for regulator good and chip select high.
// - At power-on, chip select low stays ready, high goes to operation.
// - Operation runs everything; chip select falling edge enters power-down.
// - Fault line low means transmitter-off mode with driver disabled.
// - Transmitter returns when fault line high and no internal fault.
// - Transmitter stays off while regulator unstable or recovering.
// - Wake flagged only after bus held low for the full filter time.
// - Thermal overload disables transmitter and regulator.
// - Regulator output under turn-off level is a fault; regulator off.
// - Enabled driver follows transmit data; receive follows the bus.
// - Debounced transmit versus bus mismatch pulls the fault line low.
// - Fault line driven low while regulator output is not good in ready, operation or transmitter-off mode.
`timescale 1ns/1ps
module ltmc_mode_ctrl #(
  parameter int unsigned WAKE_CYC    = ltmc_pkg::WAKE_FILTER_CYC,
  parameter int unsigned CONTEND_CNT = ltmc_pkg::CONTEND_CYC
) (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic batt_above_on_in,
  input  wire logic batt_below_off_in,
  input  wire logic reg_good_in,
  input  wire logic reg_under_off_in,
  input  wire logic thermal_ovl_in,
  input  wire logic bus_below_wake_in,
  input  wire logic chip_select_wake_in,
  input  wire logic fault_tx_enable_in,
  input  wire logic tx_data_in,
  output logic      fault_tx_enable_out,
  output logic      fault_tx_enable_oe_out,
  output logic      bus_line_pin_out,
  output logic      bus_line_pin_oe_out,
  output logic      rx_data_out,
  output logic      reg_enable_out,
  output logic      rx_enable_out,
  output logic      digital_reset_out,
  output logic      wake_event_out,
  output ltmc_pkg::ltmc_mode_t mode_out
);
  import ltmc_pkg::*;

  localparam int unsigned WAKE_W = $clog2(WAKE_CYC + 1);
  localparam int unsigned CONT_W = $clog2(CONTEND_CNT + 1);

  // Elaboration-time guards: a zero count would make the filters trivial.
  if (WAKE_CYC < 1) begin : g_bad_wake
    $error("ltmc_mode_ctrl: WAKE_CYC below 1");
  end
  if (CONTEND_CNT < 1) begin : g_bad_contend
    $error("ltmc_mode_ctrl: CONTEND_CNT below 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation.

  // All pin-level conditions pass the three-stage filter. Battery below off
  // resets high so the controller starts in the reset state.
  ltmc_cond_t cond_raw;
  ltmc_cond_t cond;
  logic [2:0] pins_raw;
  logic [2:0] pins_s;
  logic       reg_under_s;

  assign cond_raw = '{batt_above_on:  batt_above_on_in,
                      batt_below_off: batt_below_off_in,
                      reg_good:       reg_good_in,
                      thermal_ovl:    thermal_ovl_in,
                      bus_below_wake: bus_below_wake_in};
  assign pins_raw = {chip_select_wake_in, fault_tx_enable_in, tx_data_in};

  ltmc_sync #(.WIDTH(COND_W), .RESET_VAL(5'h08)) u_sync_cond (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .async_in   (cond_raw),
    .sync_out   (cond)
  );

  ltmc_sync #(.WIDTH(4), .RESET_VAL(4'h3)) u_sync_pins (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({reg_under_off_in, pins_raw}),
    .sync_out   ({reg_under_s, pins_s})
  );

  wire cs_s      = pins_s[2];
  wire fault_ext = pins_s[1];
  wire txd_s     = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // Wake filter and contention debounce.

  logic [WAKE_W-1:0] wake_cnt_q;
  logic [CONT_W-1:0] cont_cnt_q;
  logic              cs_prev_q;
  logic              reg_fault_q;
  ltmc_mode_t        mode_q;
  ltmc_mode_t        mode_d;

  // Counter saturates; any return above threshold restarts the filter.
  wire wake_full = (wake_cnt_q == WAKE_CYC[WAKE_W-1:0]);
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) wake_cnt_q <= '0;
    else if (!cond.bus_below_wake) wake_cnt_q <= '0;
    else if (!wake_full) wake_cnt_q <= wake_cnt_q + 1'b1;
  end
  assign wake_event_out = wake_full && (mode_q == LTMC_PDOWN);

  // Driving recessive while the bus reads dominant is contention; compare
  // only when our driver is active, else a foreign master looks like one.
  wire tx_on    = (mode_q == LTMC_OPER);
  wire mismatch = tx_on && (txd_s != !cond.bus_below_wake);
  wire cont_full = (cont_cnt_q == CONTEND_CNT[CONT_W-1:0]);
  // A flagged contention stays until the bus reads recessive again; if it
  // cleared on leaving operation mode the driver would come straight back
  // into the fight and the mode would oscillate.
  wire cont_hold = cont_full && cond.bus_below_wake;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) cont_cnt_q <= '0;
    else if (!mismatch && !cont_hold) cont_cnt_q <= '0;
    else if (!cont_full) cont_cnt_q <= cont_cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal fault and wired-AND line.

  // Regulator fault latches until regulator reports good again, so the
  // transmitter stays off across the whole recovery.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) reg_fault_q <= 1'b0;
    else if (reg_under_s) reg_fault_q <= 1'b1;
    else if (cond.reg_good) reg_fault_q <= 1'b0;
  end

  wire reg_on_mode = (mode_q == LTMC_READY) || (mode_q == LTMC_OPER) ||
                     (mode_q == LTMC_TXOFF);
  wire reg_bad = reg_on_mode && (!cond.reg_good || reg_fault_q);
  wire int_fault = cont_full || cond.thermal_ovl || reg_bad;
  // Effective line level: low when either side pulls.
  wire line_high = fault_ext && !int_fault;

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine.

  wire cs_fall = cs_prev_q && !cs_s;
  wire reg_ok  = cond.reg_good && !reg_fault_q;

  always_comb begin
    mode_d = mode_q;
    if (cond.batt_below_off) begin
      mode_d = LTMC_POR;
    end else begin
      unique case (mode_q)
        LTMC_POR: begin
          if (cond.batt_above_on) mode_d = LTMC_READY;
        end
        LTMC_READY: begin
          if (reg_ok && cs_s && line_high) mode_d = LTMC_OPER;
          else if (reg_ok && cs_s) mode_d = LTMC_TXOFF;
        end
        LTMC_OPER: begin
          if (cs_fall) mode_d = LTMC_PDOWN;
          else if (!line_high) mode_d = LTMC_TXOFF;
        end
        LTMC_TXOFF: begin
          if (!cs_s) mode_d = LTMC_PDOWN;
          else if (line_high && reg_ok) mode_d = LTMC_OPER;
        end
        LTMC_PDOWN: begin
          if (wake_full || cs_s) mode_d = LTMC_READY;
        end
        default: mode_d = LTMC_POR;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q    <= ltmc_mode_t'(MODE_RESET);
      cs_prev_q <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      cs_prev_q <= cs_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Registered outputs so the pins never glitch on a decode change.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_line_pin_oe_out    <= 1'b0;
      fault_tx_enable_oe_out <= 1'b0;
      reg_enable_out         <= 1'b0;
      rx_enable_out          <= 1'b0;
      rx_data_out            <= 1'b1;
    end else begin
      // Dominant only when enabled and transmit data low.
      bus_line_pin_oe_out    <= (mode_d == LTMC_OPER) && !txd_s;
      fault_tx_enable_oe_out <= int_fault;
      // Regulator off in reset, power-down, or on overload/fault.
      reg_enable_out <= reg_on_mode && !cond.thermal_ovl &&
                        !reg_under_s;
      rx_enable_out  <= (mode_q != LTMC_POR);
      rx_data_out    <= !cond.bus_below_wake;
    end
  end

  assign bus_line_pin_out    = 1'b0;
  assign fault_tx_enable_out = 1'b0;
  assign digital_reset_out   = (mode_q == LTMC_POR);
  assign mode_out            = mode_q;

endmodule : ltmc_mode_ctrl

// ---- tb/ltmc_host_model.sv ----
// Host side model: chip select, transmit data, fault line and bus wiring.
// Assumes the bench changes its requests just after a clock edge.
`timescale 1ns/1ps
module ltmc_host_model (
  input  wire logic cs_req_in,
  input  wire logic txd_req_in,
  input  wire logic fault_pull_in,
  input  wire logic node_dom_in,
  input  wire logic dev_fault_oe_in,
  input  wire logic dev_bus_oe_in,
  output logic      cs_out,
  output logic      txd_out,
  output logic      fault_line_out,
  output logic      bus_low_out
);
  // Both lines carry pull-ups, so a released line reads high.
  assign cs_out         = cs_req_in;
  assign txd_out        = txd_req_in;
  assign fault_line_out = !(fault_pull_in || dev_fault_oe_in);
  assign bus_low_out    = dev_bus_oe_in || node_dom_in;
endmodule : ltmc_host_model

// ---- tb/ltmc_mode_ctrl_chk.sv ----
// Port assertions for the transceiver mode controller.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ps
module ltmc_mode_ctrl_chk
  import ltmc_pkg::*;
#(
  parameter int unsigned WAKE_CYC = 4
) (
  input wire logic       mclk_in,
  input wire logic       reset_n_in,
  input wire logic       batt_below_off_in,
  input wire logic       reg_good_in,
  input wire logic       reg_under_off_in,
  input wire logic       thermal_ovl_in,
  input wire logic       bus_below_wake_in,
  input wire logic       fault_tx_enable_oe_out,
  input wire logic       bus_line_pin_oe_out,
  input wire logic       reg_enable_out,
  input wire logic       digital_reset_out,
  input wire logic       wake_event_out,
  input wire ltmc_mode_t mode_out
);
  logic [15:0] low_cnt_q;
  // Raw low time of the bus; it saturates so long idles cannot wrap.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) low_cnt_q <= 16'h0000;
    else if (!bus_below_wake_in) low_cnt_q <= 16'h0000;
    else if (low_cnt_q != 16'hffff) low_cnt_q <= low_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // Seven edges cover the input filter plus the mode step.
  sequence s_batt_gone; batt_below_off_in [*7]; endsequence
  sequence s_heat; thermal_ovl_in [*7]; endsequence
  sequence s_reg_bad; (reg_under_off_in && !reg_good_in) [*7]; endsequence
  chk_batt_por: assert property (s_batt_gone |=> mode_out == LTMC_POR)
    else $error("mode not reset after battery loss");
  chk_por_reset: assert property (mode_out == LTMC_POR |-> digital_reset_out)
    else $error("digital reset low in reset mode");
  chk_pdown_off: assert property (mode_out == LTMC_PDOWN [*2] |->
    !reg_enable_out && !bus_line_pin_oe_out)
    else $error("power-down left regulator or driver on");
  chk_pdown_entry: assert property ($changed(mode_out) && mode_out == LTMC_PDOWN
    |-> $past(mode_out) inside {LTMC_OPER, LTMC_TXOFF})
    else $error("power-down entered from a wrong mode");
  chk_ready_quiet: assert property (mode_out == LTMC_READY |-> !bus_line_pin_oe_out)
    else $error("driver on in ready mode");
  chk_txoff_quiet: assert property (mode_out == LTMC_TXOFF |-> !bus_line_pin_oe_out)
    else $error("driver on in transmitter-off mode");
  chk_wake_ready: assert property (wake_event_out |=> mode_out == LTMC_READY)
    else $error("wake did not lead to ready");
  chk_wake_filter: assert property ($rose(wake_event_out) |-> low_cnt_q >= WAKE_CYC)
    else $error("wake flagged before filter time");
  chk_heat_off: assert property (s_heat |=> !reg_enable_out && !bus_line_pin_oe_out)
    else $error("overload left regulator or driver on");
  chk_reg_fault: assert property (s_reg_bad |=>
    !bus_line_pin_oe_out && fault_tx_enable_oe_out)
    else $error("regulator fault not signalled");
endmodule : ltmc_mode_ctrl_chk
bind ltmc_mode_ctrl ltmc_mode_ctrl_chk #(.WAKE_CYC(WAKE_CYC)) u_chk (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in),
  .batt_below_off_in(batt_below_off_in), .reg_good_in(reg_good_in),
  .reg_under_off_in(reg_under_off_in), .thermal_ovl_in(thermal_ovl_in),
  .bus_below_wake_in(bus_below_wake_in),
  .fault_tx_enable_oe_out(fault_tx_enable_oe_out),
  .bus_line_pin_oe_out(bus_line_pin_oe_out), .reg_enable_out(reg_enable_out),
  .digital_reset_out(digital_reset_out), .wake_event_out(wake_event_out),
  .mode_out(mode_out));

// ---- tb/ltmc_mode_ctrl_tb.sv ----
// Self-checking bench for the mode controller with a host model.
// Assumes short filter counts so each step settles within sixteen cycles;
// the contention count must exceed the driver-to-receiver loop delay.
`timescale 1ns/1ps
module ltmc_mode_ctrl_tb;
  import ltmc_pkg::*;
  typedef struct packed {
    logic bon, boff, rg, cs;
    ltmc_mode_t m;
  } ltmc_row_t;
  logic mclk_in = 0, reset_n_in = 0, bon = 0, boff = 1, rg = 0, ru = 0;
  logic heat = 0, cs_req = 0, txd_req = 1, fpull = 0, ndom = 0;
  logic cs, txd, fline, bus_low, f_oe, b_oe, rxd, reg_en, dreset, rx_en;
  logic f_dat, b_dat;
  ltmc_mode_t mode;
  int bad_count = 0, num_checks = 0;
  ltmc_row_t rows [6] = '{
    '{1'b0, 1'b1, 1'b0, 1'b0, LTMC_POR},
    '{1'b1, 1'b0, 1'b1, 1'b0, LTMC_READY},
    '{1'b1, 1'b0, 1'b1, 1'b1, LTMC_OPER},
    '{1'b1, 1'b0, 1'b1, 1'b0, LTMC_PDOWN},
    '{1'b1, 1'b0, 1'b1, 1'b1, LTMC_OPER},
    '{1'b0, 1'b1, 1'b1, 1'b1, LTMC_POR}};
  always #10 mclk_in = ~mclk_in;
  ltmc_host_model host (.cs_req_in(cs_req), .txd_req_in(txd_req),
    .fault_pull_in(fpull), .node_dom_in(ndom), .dev_fault_oe_in(f_oe),
    .dev_bus_oe_in(b_oe), .cs_out(cs), .txd_out(txd),
    .fault_line_out(fline), .bus_low_out(bus_low));
  ltmc_mode_ctrl #(.WAKE_CYC(4), .CONTEND_CNT(8)) dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .batt_above_on_in(bon),
    .batt_below_off_in(boff), .reg_good_in(rg), .reg_under_off_in(ru),
    .thermal_ovl_in(heat), .bus_below_wake_in(bus_low),
    .chip_select_wake_in(cs), .fault_tx_enable_in(fline),
    .tx_data_in(txd), .fault_tx_enable_out(f_dat),
    .fault_tx_enable_oe_out(f_oe),
    .bus_line_pin_out(b_dat), .bus_line_pin_oe_out(b_oe), .rx_data_out(rxd),
    .reg_enable_out(reg_en), .rx_enable_out(rx_en), .digital_reset_out(dreset),
    .wake_event_out(), .mode_out(mode));
  // Inputs move a fixed 2 ns after the edge, so no sampling race exists.
  task automatic go(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask : go
  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_mode(input ltmc_mode_t e);
    num_checks++;
    if (mode !== e) begin
      bad_count++;
      $display("mismatch mode expected %h seen %h", e, mode);
    end
  endtask : chk_mode
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // The whole run needs about 230 cycles; 3000 means a hang.
  initial begin
    #(20 * 3000);
    bad_count++;
    report_and_stop();
  end
  initial begin
    go(19);
    chk_mode(LTMC_POR);
    chk_bit("digital_reset", 1'b1, dreset);
    chk_bit("rx_enable", 1'b0, rx_en);
    go(1);
    reset_n_in = 1;
    foreach (rows[i]) begin
      {bon, boff, rg, cs_req} = {rows[i].bon, rows[i].boff, rows[i].rg,
                                 rows[i].cs};
      go(12);
      chk_mode(rows[i].m);
      $display("row %0d done", i);
    end
    {bon, boff} = 2'b10;
    go(12);
    chk_mode(LTMC_OPER);
    txd_req = 0;
    go(12);
    chk_bit("bus_oe", 1'b1, b_oe);
    chk_bit("rx_data", 1'b0, rxd);
    chk_bit("bus_data", 1'b0, b_dat);
    chk_bit("fault_data", 1'b0, f_dat);
    txd_req = 1;
    fpull = 1;
    go(8);
    chk_mode(LTMC_TXOFF);
    fpull = 0;
    go(8);
    chk_mode(LTMC_OPER);
    $display("driver and fault line done");
    ndom = 1;
    go(16);
    chk_bit("fault_oe", 1'b1, f_oe);
    chk_mode(LTMC_TXOFF);
    chk_bit("rx_data", 1'b0, rxd);
    ndom = 0;
    go(12);
    chk_mode(LTMC_OPER);
    {rg, ru, txd_req} = 3'b010;
    go(8);
    chk_bit("bus_oe", 1'b0, b_oe);
    chk_bit("fault_oe", 1'b1, f_oe);
    ru = 0;
    go(6);
    chk_bit("bus_oe", 1'b0, b_oe);
    rg = 1;
    go(12);
    chk_bit("bus_oe", 1'b1, b_oe);
    txd_req = 1;
    heat = 1;
    go(8);
    chk_bit("reg_enable", 1'b0, reg_en);
    heat = 0;
    cs_req = 0;
    go(12);
    chk_mode(LTMC_PDOWN);
    chk_bit("reg_enable", 1'b0, reg_en);
    $display("fault recovery done");
    ndom = 1;
    go(2);
    ndom = 0;
    go(10);
    chk_mode(LTMC_PDOWN);
    ndom = 1;
    go(12);
    chk_mode(LTMC_READY);
    chk_bit("reg_enable", 1'b1, reg_en);
    chk_bit("rx_enable", 1'b1, rx_en);
    $display("wake filter done");
    report_and_stop();
  end
endmodule : ltmc_mode_ctrl_tb
